// ### dv/rkpm_panel.sv
`default_nettype none
module rkpm_panel (
  input wire logic        clk,
  input wire logic        wg_valid,
  input wire logic [44:0] wg_data,
  input wire logic [5:0]  wg_len,
  output logic            wg_ready,
  output logic     [50:0] last_frame
);
  logic [1:0] cnt_q = 2'h0;
  // ready two cycles of four, so the output buffer sees stalls
  assign wg_ready = cnt_q[1];
  always_ff @(posedge clk)
  begin
    cnt_q <= cnt_q + 2'h1;
    if (wg_valid && wg_ready)
      last_frame <= {wg_len, wg_data};
  end
endmodule
`default_nettype wire

// ### dv/rkpm_props.sv
`default_nettype none
module rkpm_props (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        wiegand_mode,
  input wire logic        hw_addr_mode,
  input wire logic        tamper_sense,
  input wire logic        io_port_n,
  input wire logic        wg_valid,
  input wire logic [44:0] wg_data,
  input wire logic [5:0]  wg_len,
  input wire logic        wg_ready,
  input wire logic        led_red,
  input wire logic        relay,
  input wire logic        prog_active
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  a_wg_hold: assert property (wg_valid && !wg_ready |=> wg_valid)
    else $error("frame lost under stall");
  a_wg_keep: assert property (wg_valid && !wg_ready |=> $stable(wg_data))
    else $error("frame data moved under stall");
  a_key_range: assert property (wg_valid && wg_len == 6'h04 |-> wg_data < 45'hC)
    else $error("key code out of range");
  a_relay_on: assert property ((wiegand_mode && tamper_sense) [*8] |-> relay)
    else $error("relay off while tampered");
  a_relay_off: assert property ((io_port_n && !tamper_sense) [*8] |-> !relay)
    else $error("relay on without tamper");
  a_relay_idle: assert property (!wiegand_mode [*2] |-> !relay)
    else $error("relay on outside wiegand mode");
  a_red_lit: assert property (wiegand_mode [*3] |-> led_red)
    else $error("red led off");
  a_prog_block: assert property (hw_addr_mode && !prog_active |=> !prog_active)
    else $error("programming entered in address mode");
endmodule
`default_nettype wire

// ### dv/rkpm_top_tb.sv
`default_nettype none
module rkpm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, reset = 1'h1, wiegand_mode, pin_sched_suppress, sched_valid;
  logic intrusion_alarm_system_mode, intrusion_alarm_system_toggle;
  logic hw_addr_mode, card_valid, card_tech, card_ready, key_valid, key_ready, beep_in_n, relay;
  logic yellow_in_n, io_port_n, tamper_sense, wg_valid, wg_ready, beeper, led_red, led_green;
  logic led_yellow, pin_required, keypad_locked, prog_active, digit_valid, entry_cancel;
  logic entry_submit, reason_valid, user_valid, user_found, user_always;
  logic [1:0] keypad_cfg, em_fmt_sel;
  logic [3:0] key_code, digit, reason, ex;
  logic [5:0] card_len, wg_len;
  logic [7:0] lock_time_cfg;
  logic [19:0] user_pin;
  logic [44:0] prog_ins_id, prog_del_id, card_id, wg_data;
  logic [50:0] last_frame;
  int err_total = 0, cmp_count = 0;
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_total++; \
  $display("mismatch %s expected %0h seen %0h", n, e, s); end end
  always #25 clk = ~clk;
  rkpm_top #(.TICK_CYC(4)) i_dut (.*);
  rkpm_panel i_panel (.*);
  task put(input logic is_key, input logic [44:0] v);
    // a fresh cycle first, so back-to-back calls never rewrite valid in one step
    @(negedge clk);
    {card_id, key_code, card_valid, key_valid} = {v, v[3:0], !is_key, is_key};
    while ((is_key ? key_ready : card_ready) !== 1'h1) @(negedge clk);
    @(posedge clk);
    @(negedge clk) {card_valid, key_valid} = 2'h0;
  endtask
  task t_key;
    for (int i = 0; i < 4; i++)
    begin
      keypad_cfg = i[1] ? rkpm_pkg::KP_PIN : rkpm_pkg::KP_CODE;
      ex = (i[0] ^ i[1]) ? rkpm_pkg::CODE_0 : rkpm_pkg::CODE_10;
      put(1'h1, 45'(i[0] ? rkpm_pkg::KEY_STAR : rkpm_pkg::KEY_0));
      repeat (10) @(negedge clk);
      `CHK("key frame", {rkpm_pkg::WG_LEN_KEY, 45'(ex)}, last_frame)
    end
    $display("t_key done");
  endtask
  task t_card;
    em_fmt_sel = rkpm_pkg::EM_FMT_42;
    put(1'h0, 45'h1ABCD);
    tamper_sense = 1'h1;
    repeat (10) @(negedge clk);
    `CHK("frame", {rkpm_pkg::WG_LEN_42, 45'h1ABCD}, last_frame)
    `CHK("green", 1'h1, led_green)
    tamper_sense = 1'h0;
    repeat (10) @(negedge clk);
    {card_tech, card_len} = {1'h1, 6'h2D};
    put(1'h0, 45'h1ABCE);
    repeat (10) @(negedge clk);
    `CHK("second tech", {6'h2D, 45'h1ABCE}, last_frame)
    card_tech = 1'h0;
    $display("t_card done");
  endtask
  task t_pins;
    `CHK("power-up beep", 1'h1, beeper)
    repeat (700) @(negedge clk);
    `CHK("beep end", 1'h0, beeper)
    {beep_in_n, yellow_in_n} = 2'h0;
    repeat (8) @(negedge clk);
    `CHK("panel beep", 1'h1, beeper)
    `CHK("panel yellow", 1'h1, led_yellow)
    {beep_in_n, yellow_in_n} = 2'h3;
    repeat (8) @(negedge clk);
    `CHK("yellow off", 1'h0, led_yellow)
    $display("t_pins done");
  endtask
  task t_local;
    {wiegand_mode, keypad_cfg, lock_time_cfg} = {1'h0, rkpm_pkg::KP_CODE, 8'h01};
    put(1'h1, 45'(rkpm_pkg::KEY_0));
    `CHK("reason", {1'h1, rkpm_pkg::CODE_10}, {reason_valid, reason})
    keypad_cfg = rkpm_pkg::KP_PIN;
    put(1'h1, 45'h7);
    `CHK("digit", 5'h17, {digit_valid, digit})
    `CHK("pin request", 1'h1, pin_required)
    put(1'h1, 45'(rkpm_pkg::KEY_STAR));
    `CHK("cancel", 1'h1, entry_cancel)
    put(1'h1, 45'(rkpm_pkg::KEY_HASH));
    `CHK("submit", 1'h1, entry_submit)
    intrusion_alarm_system_mode = 1'h1;
    put(1'h1, 45'(rkpm_pkg::KEY_HASH));
    `CHK("alarm toggle", 1'h1, intrusion_alarm_system_toggle)
    {intrusion_alarm_system_mode, pin_sched_suppress, sched_valid} = 3'h3;
    repeat (3) @(negedge clk);
    `CHK("pin suppressed", 1'h0, pin_required)
    keypad_cfg = rkpm_pkg::KP_ID;
    repeat (5)
    begin
      put(1'h1, 45'h9);
      put(1'h1, 45'(rkpm_pkg::KEY_HASH));
    end
    repeat (25) @(negedge clk);
    `CHK("keypad lock", 1'h1, keypad_locked)
    put(1'h1, 45'h3);
    `CHK("locked key", 1'h0, digit_valid)
    $display("t_local done");
  endtask
  task t_prog;
    wiegand_mode = 1'h0;
    put(1'h0, prog_ins_id);
    put(1'h0, 45'h1234);
    repeat (5000) @(negedge clk);
    `CHK("prog held", 1'h1, prog_active)
    repeat (1200) @(negedge clk);
    `CHK("prog left", 1'h0, prog_active)
    put(1'h0, 45'h1234);
    for (int n = 0; n < 30 && user_valid !== 1'h1; n++) @(negedge clk);
    `CHK("user", {2'h3, rkpm_pkg::DEF_PIN}, {user_found, user_always, user_pin})
    put(1'h0, prog_del_id);
    `CHK("delete mode", 1'h1, prog_active)
    repeat (5) put(1'h0, prog_del_id);
    `CHK("erase all exit", 1'h0, prog_active)
    put(1'h0, 45'h1234);
    for (int n = 0; n < 30 && user_valid !== 1'h1; n++) @(negedge clk);
    `CHK("erased user", 2'h2, {user_valid, user_found})
    hw_addr_mode = 1'h1;
    put(1'h0, prog_ins_id);
    repeat (5) @(negedge clk);
    `CHK("address mode", 1'h0, prog_active)
    $display("t_prog done");
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #1000000 err_total++;
    test_done;
  end
  initial
  begin
    {wiegand_mode, intrusion_alarm_system_mode} = 2'h2;
    {pin_sched_suppress, sched_valid, hw_addr_mode} = 3'h0;
    {card_valid, card_tech, key_valid, io_port_n, tamper_sense} = 5'h02;
    {beep_in_n, yellow_in_n} = 2'h3;
    {keypad_cfg, em_fmt_sel, key_code, card_len, lock_time_cfg, card_id} = '0;
    {prog_ins_id, prog_del_id} = {45'hAAA, 45'hBBB};
    repeat (5) @(negedge clk);
    reset = 1'h0;
    @(negedge clk);
    t_key;
    t_card;
    t_pins;
    t_local;
    t_prog;
    test_done;
  end
endmodule
bind rkpm_top rkpm_props i_props (.*);
`default_nettype wire

// ### hdl/rkpm_store.sv
`default_nettype none
module rkpm_store (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       we,
  input  wire logic [rkpm_pkg::IDX_W-1:0] widx,
  input  wire logic [rkpm_pkg::ENT_W-1:0] wdata,
  input  wire logic                       clr,
  input  wire logic [rkpm_pkg::IDX_W-1:0] cidx,
  input  wire logic                       clr_all,
  input  wire logic [rkpm_pkg::IDX_W-1:0] ridx,
  output logic      [rkpm_pkg::ENT_W-1:0] rdata,
  output logic                            rvalid
);
  typedef struct packed {
    logic [rkpm_pkg::DEPTH-1:0]                      vld;
    logic [rkpm_pkg::DEPTH-1:0][rkpm_pkg::ENT_W-1:0] ent;
    logic [rkpm_pkg::ENT_W-1:0]                      rdata;
    logic                                            rvalid;
  } rkpm_store_st_t;

  rkpm_store_st_t q;
  rkpm_store_st_t d;

  always_comb
  begin
    d = q;
    d.rdata = q.ent[ridx];
    d.rvalid = q.vld[ridx];
    if (clr_all)
      d.vld = '0;
    if (clr)
      d.vld[cidx] = 1'b0;
    if (we)
    begin
      d.vld[widx] = 1'b1;
      d.ent[widx] = wdata;
    end
  end

  // contents are lost on reset; a real part keeps them in non-volatile storage
  always_ff @(posedge clk)
  begin
    if (reset)
      q <= '0;
    else
      q <= d;
  end

  assign rdata = q.rdata;
  assign rvalid = q.rvalid;
endmodule
`default_nettype wire

// ### hdl/rkpm_top.sv
`default_nettype none
module rkpm_top #(
  parameter int unsigned TICK_CYC = rkpm_pkg::TICK_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      wiegand_mode,
  input  wire logic                      intrusion_alarm_system_mode,
  input  wire logic [1:0]                keypad_cfg,
  input  wire logic [1:0]                em_fmt_sel,
  input  wire logic                      pin_sched_suppress,
  input  wire logic                      sched_valid,
  input  wire logic [7:0]                lock_time_cfg,
  input  wire logic                      hw_addr_mode,
  input  wire logic [rkpm_pkg::ID_W-1:0] prog_ins_id,
  input  wire logic [rkpm_pkg::ID_W-1:0] prog_del_id,
  input  wire logic                      card_valid,
  input  wire logic [rkpm_pkg::ID_W-1:0] card_id,
  input  wire logic                      card_tech,
  input  wire logic [5:0]                card_len,
  output logic                           card_ready,
  input  wire logic                      key_valid,
  input  wire logic [3:0]                key_code,
  output logic                           key_ready,
  input  wire logic                      beep_in_n,
  input  wire logic                      yellow_in_n,
  input  wire logic                      io_port_n,
  input  wire logic                      tamper_sense,
  output logic                           wg_valid,
  output logic      [rkpm_pkg::ID_W-1:0] wg_data,
  output logic      [5:0]                wg_len,
  input  wire logic                      wg_ready,
  output logic                           beeper,
  output logic                           led_red,
  output logic                           led_green,
  output logic                           led_yellow,
  output logic                           relay,
  output logic                           pin_required,
  output logic                           keypad_locked,
  output logic                           prog_active,
  output logic                           digit_valid,
  output logic      [3:0]                digit,
  output logic                           entry_cancel,
  output logic                           entry_submit,
  output logic                           reason_valid,
  output logic      [3:0]                reason,
  output logic                           intrusion_alarm_system_toggle,
  output logic                           user_valid,
  output logic                           user_found,
  output logic      [rkpm_pkg::PIN_W-1:0] user_pin,
  output logic                           user_always
);
  typedef struct packed {
    logic [23:0]                        tick_cnt;
    logic                               tick;
    logic [3:0][2:0]                    sy;
    logic [3:0]                         filt;
    logic [7:0]                         pu_cnt;
    logic [3:0]                         grn;
    logic [7:0]                         flash;
    rkpm_pkg::rkpm_pm_t                 pm;
    logic [10:0]                        pm_tmr;
    logic [2:0]                         rep;
    logic [rkpm_pkg::IDX_W-1:0]         ref_idx;
    logic [rkpm_pkg::IDX_W-1:0]         last;
    logic                               sc_run;
    rkpm_pkg::rkpm_purp_t               purp;
    logic                               sc_typed;
    logic [rkpm_pkg::IDX_W:0]           sc_idx;
    logic                               cmp_v;
    logic [rkpm_pkg::IDX_W-1:0]         cmp_idx;
    logic [rkpm_pkg::ID_W-1:0]          sc_key;
    logic [4*rkpm_pkg::DIG_N-1:0]       digits;
    logic [3:0]                         ndig;
    logic [2:0]                         unk;
    logic [17:0]                        lock;
    logic                               m_we;
    logic                               m_clr;
    logic                               m_clr_all;
    logic [rkpm_pkg::IDX_W-1:0]         m_widx;
    logic [rkpm_pkg::IDX_W-1:0]         m_cidx;
    logic [rkpm_pkg::ENT_W-1:0]         m_wdata;
    logic [1:0]                         b_v;
    logic [1:0][rkpm_pkg::ID_W-1:0]     b_data;
    logic [1:0][5:0]                    b_len;
    logic                               rdy;
    logic                               beeper;
    logic                               red;
    logic                               yellow;
    logic                               relay;
    logic                               pin_req;
    logic                               dig_v;
    logic [3:0]                         dig;
    logic                               cancel;
    logic                               submit;
    logic                               reason_v;
    logic [3:0]                         reason;
    logic                               ias_tog;
    logic                               user_v;
    logic                               user_hit;
    logic [rkpm_pkg::PIN_W-1:0]         user_pin;
    logic                               user_alw;
    logic                               green;
    logic                               locked;
    logic                               prog;
  } rkpm_top_st_t;

  rkpm_top_st_t q;
  rkpm_top_st_t d;

  logic [rkpm_pkg::ENT_W-1:0] m_rdata;
  logic                       m_rvalid;
  logic [3:0]                 pin_raw;
  logic                       card_take;
  logic                       key_take;
  logic                       typed;
  logic                       cv;
  logic                       ctyp;
  logic [rkpm_pkg::ID_W-1:0]  cid;
  logic                       is_ins;
  logic                       is_del;
  logic                       push;
  logic [rkpm_pkg::ID_W-1:0]  pdata;
  logic [5:0]                 plen;
  logic [3:0]                 rmap;
  logic                       is_digit;
  logic                       hit;
  logic                       pu_beep;
  logic                       tamper_any;

  assign pin_raw = {tamper_sense, io_port_n, yellow_in_n, beep_in_n};

  always_comb
  begin
    d = q;
    card_take = card_valid & q.rdy;
    // a key waits while a card is offered, so one word at most enters per cycle
    key_take = key_valid & q.rdy & ~card_valid;
    typed = 1'b0;
    cv = 1'b0;
    ctyp = 1'b0;
    cid = '0;
    push = 1'b0;
    pdata = '0;
    plen = '0;
    hit = 1'b0;
    d.dig_v = 1'b0;
    d.cancel = 1'b0;
    d.submit = 1'b0;
    d.reason_v = 1'b0;
    d.ias_tog = 1'b0;
    d.user_v = 1'b0;
    d.m_we = 1'b0;
    d.m_clr = 1'b0;
    d.m_clr_all = 1'b0;

    d.tick = 1'b0;
    if (q.tick_cnt == 24'(TICK_CYC - 1))
    begin
      d.tick_cnt = '0;
      d.tick = 1'b1;
    end
    else
      d.tick_cnt = q.tick_cnt + 24'h1;

    // only the second and third stages are looked at
    for (int i = 0; i < 4; i++)
    begin
      d.sy[i] = {q.sy[i][1:0], pin_raw[i]};
      if (q.sy[i][2] == q.sy[i][1])
        d.filt[i] = q.sy[i][2];
    end

    if (q.tick)
    begin
      d.flash = q.flash + 8'h1;
      if (q.pu_cnt != rkpm_pkg::PU_END_TK)
        d.pu_cnt = q.pu_cnt + 8'h1;
      if (q.grn != '0)
        d.grn = q.grn - 4'h1;
      if (q.lock != '0)
        d.lock = q.lock - 18'h1;
      if (q.pm != rkpm_pkg::PM_OFF)
      begin
        if (q.pm_tmr == '0)
        begin
          d.pm = rkpm_pkg::PM_OFF;
          d.rep = '0;
        end
        else
          d.pm_tmr = q.pm_tmr - 11'h1;
      end
    end

    // reason numbering; also the wiegand code of a key-code keypad
    if (key_code == rkpm_pkg::KEY_0)
      rmap = rkpm_pkg::CODE_10;
    else if (key_code == rkpm_pkg::KEY_STAR)
      rmap = rkpm_pkg::CODE_0;
    else
      rmap = key_code;
    is_digit = key_code < rkpm_pkg::KEY_STAR;

    if (key_take)
    begin
      if (wiegand_mode)
      begin
        push = 1'b1;
        plen = rkpm_pkg::WG_LEN_KEY;
        pdata = {41'h0, (keypad_cfg == rkpm_pkg::KP_CODE) ? rmap : key_code};
      end
      else if (q.lock == '0)
      begin
        if (key_code == rkpm_pkg::KEY_HASH && intrusion_alarm_system_mode && q.ndig == '0)
          d.ias_tog = 1'b1;
        else if (keypad_cfg == rkpm_pkg::KP_CODE)
        begin
          d.reason_v = 1'b1;
          d.reason = rmap;
          if (key_code == rkpm_pkg::KEY_HASH)
            typed = (q.pm != rkpm_pkg::PM_OFF) || ({1'b0, q.digits} == prog_ins_id)
                    || ({1'b0, q.digits} == prog_del_id);
        end
        else
        begin
          d.dig_v = is_digit;
          d.dig = key_code;
          d.cancel = key_code == rkpm_pkg::KEY_STAR;
          d.submit = key_code == rkpm_pkg::KEY_HASH;
          typed = d.submit && keypad_cfg == rkpm_pkg::KP_ID;
        end
        if (is_digit)
        begin
          d.digits = {q.digits[4*rkpm_pkg::DIG_N-5:0], key_code};
          if (q.ndig != 4'(rkpm_pkg::DIG_N))
            d.ndig = q.ndig + 4'h1;
        end
        else
        begin
          d.digits = '0;
          d.ndig = '0;
        end
      end
    end

    if (card_take)
    begin
      cv = 1'b1;
      cid = card_id;
    end
    else if (typed)
    begin
      cv = 1'b1;
      ctyp = 1'b1;
      cid = {1'b0, q.digits};
    end
    is_ins = cid == prog_ins_id;
    is_del = cid == prog_del_id;

    if (cv && (is_ins || is_del))
    begin
      case (q.pm)
        rkpm_pkg::PM_OFF:
          if (!hw_addr_mode)
          begin
            d.pm = is_ins ? rkpm_pkg::PM_INS : rkpm_pkg::PM_DEL;
            d.rep = '0;
            d.pm_tmr = rkpm_pkg::PROG_TK;
          end
        rkpm_pkg::PM_INS:
          if (is_ins)
          begin
            d.pm_tmr = rkpm_pkg::PROG_TK;
            if (q.rep == rkpm_pkg::REPEAT_N - 3'h1)
            begin
              d.pm = rkpm_pkg::PM_NBR;
              d.rep = '0;
            end
            else
              d.rep = q.rep + 3'h1;
          end
          else
            d.rep = '0;
        rkpm_pkg::PM_DEL:
          if (is_del)
          begin
            d.pm_tmr = rkpm_pkg::PROG_TK;
            if (q.rep == rkpm_pkg::REPEAT_N - 3'h1)
            begin
              d.m_clr_all = 1'b1;
              d.last = 4'(rkpm_pkg::DEPTH - 1);
              d.pm = rkpm_pkg::PM_OFF;
              d.rep = '0;
            end
            else
              d.rep = q.rep + 3'h1;
          end
          else
            d.rep = '0;
        rkpm_pkg::PM_REF:
        begin
          d.m_clr = 1'b1;
          d.m_cidx = is_del ? q.ref_idx - 4'h1 : q.ref_idx + 4'h1;
          d.pm = rkpm_pkg::PM_OFF;
        end
        default:
          d.pm = q.pm;
      endcase
    end
    else if (cv)
    begin
      d.rep = '0;
      d.sc_key = cid;
      d.sc_typed = ctyp;
      d.sc_idx = '0;
      d.cmp_v = 1'b0;
      if (q.pm == rkpm_pkg::PM_INS)
      begin
        d.m_we = 1'b1;
        d.m_widx = q.last + 4'h1;
        d.last = q.last + 4'h1;
        d.m_wdata = {1'b1, rkpm_pkg::DEF_PIN, cid};
        d.pm_tmr = rkpm_pkg::PROG_TK;
      end
      else if (q.pm != rkpm_pkg::PM_OFF)
      begin
        d.sc_run = 1'b1;
        d.purp = (q.pm == rkpm_pkg::PM_DEL) ? rkpm_pkg::SP_DEL : rkpm_pkg::SP_REF;
        d.pm_tmr = rkpm_pkg::PROG_TK;
      end
      else if (wiegand_mode && !ctyp)
      begin
        push = 1'b1;
        pdata = cid;
        d.grn = rkpm_pkg::GREEN_TK;
        if (card_tech)
          plen = card_len;
        else if (em_fmt_sel == rkpm_pkg::EM_FMT_26)
          plen = rkpm_pkg::WG_LEN_26;
        else if (em_fmt_sel == rkpm_pkg::EM_FMT_32)
          plen = rkpm_pkg::WG_LEN_32;
        else if (em_fmt_sel == rkpm_pkg::EM_FMT_42)
          plen = rkpm_pkg::WG_LEN_42;
        else
          plen = rkpm_pkg::WG_LEN_44;
      end
      else
      begin
        d.sc_run = 1'b1;
        d.purp = rkpm_pkg::SP_LOOK;
      end
    end

    // linear search; memory read data lag the index by one cycle
    if (q.sc_run)
    begin
      hit = q.cmp_v && m_rvalid && (m_rdata[rkpm_pkg::ID_W-1:0] == q.sc_key);
      d.cmp_v = ~q.sc_idx[rkpm_pkg::IDX_W];
      d.cmp_idx = q.sc_idx[rkpm_pkg::IDX_W-1:0];
      if (!q.sc_idx[rkpm_pkg::IDX_W])
        d.sc_idx = q.sc_idx + 5'h1;
      if (hit || (q.cmp_v && q.cmp_idx == 4'(rkpm_pkg::DEPTH - 1)))
      begin
        d.sc_run = 1'b0;
        d.cmp_v = 1'b0;
        case (q.purp)
          rkpm_pkg::SP_LOOK:
          begin
            d.user_v = 1'b1;
            d.user_hit = hit;
            d.user_pin = m_rdata[rkpm_pkg::PIN_LSB +: rkpm_pkg::PIN_W];
            d.user_alw = m_rdata[rkpm_pkg::ALW_POS];
            if (hit)
              d.grn = rkpm_pkg::GREEN_TK;
            if (q.sc_typed && hit)
              d.unk = '0;
            else if (q.sc_typed && q.unk == rkpm_pkg::UNKNOWN_N - 3'h1)
            begin
              d.unk = '0;
              d.lock = 18'(lock_time_cfg * rkpm_pkg::LOCK_STEP_TK);
            end
            else if (q.sc_typed)
              d.unk = q.unk + 3'h1;
          end
          rkpm_pkg::SP_DEL:
            if (hit)
            begin
              d.m_clr = 1'b1;
              d.m_cidx = q.cmp_idx;
            end
          default:
            if (hit)
            begin
              d.ref_idx = q.cmp_idx;
              d.pm = rkpm_pkg::PM_REF;
            end
        endcase
      end
    end

    // two-entry output buffer, head in slot 0
    if (wg_ready && q.b_v[0])
    begin
      d.b_v = {1'b0, q.b_v[1]};
      d.b_data[0] = q.b_data[1];
      d.b_len[0] = q.b_len[1];
    end
    if (push)
    begin
      if (!d.b_v[0])
      begin
        d.b_v[0] = 1'b1;
        d.b_data[0] = pdata;
        d.b_len[0] = plen;
      end
      else
      begin
        d.b_v[1] = 1'b1;
        d.b_data[1] = pdata;
        d.b_len[1] = plen;
      end
    end
    // a slot stays spare for the word already on its way
    d.rdy = ~d.b_v[1] & ~d.sc_run;

    pu_beep = (q.pu_cnt < rkpm_pkg::BEEP_TK) || (q.pu_cnt >= 8'(2 * rkpm_pkg::BEEP_TK)
              && q.pu_cnt != rkpm_pkg::PU_END_TK);
    tamper_any = q.filt[3] | ~q.filt[2];
    d.beeper = wiegand_mode & (pu_beep | ~q.filt[0]);
    d.red = wiegand_mode;
    d.relay = wiegand_mode & tamper_any;
    if (q.pm == rkpm_pkg::PM_NBR || q.pm == rkpm_pkg::PM_REF)
      d.yellow = q.flash[rkpm_pkg::FLASH_FAST_BIT];
    else if (q.pm != rkpm_pkg::PM_OFF)
      d.yellow = q.flash[rkpm_pkg::FLASH_SLOW_BIT];
    else
      d.yellow = wiegand_mode & ~q.filt[1];
    d.pin_req = ~wiegand_mode && keypad_cfg == rkpm_pkg::KP_PIN
                && !(pin_sched_suppress && sched_valid);
    // status levels registered so every top output leaves a flip-flop
    d.green = d.grn != '0;
    d.locked = d.lock != '0;
    d.prog = d.pm != rkpm_pkg::PM_OFF;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      q <= '0;
      q.filt <= rkpm_pkg::FILT_RST;
      q.pm <= rkpm_pkg::PM_OFF;
      q.purp <= rkpm_pkg::SP_LOOK;
      q.last <= 4'(rkpm_pkg::DEPTH - 1);
    end
    else
      q <= d;
  end

  rkpm_store u_store (
    .clk     (clk),
    .reset   (reset),
    .we      (q.m_we),
    .widx    (q.m_widx),
    .wdata   (q.m_wdata),
    .clr     (q.m_clr),
    .cidx    (q.m_cidx),
    .clr_all (q.m_clr_all),
    .ridx    (q.sc_idx[rkpm_pkg::IDX_W-1:0]),
    .rdata   (m_rdata),
    .rvalid  (m_rvalid)
  );

  assign card_ready = q.rdy;
  assign key_ready = q.rdy;
  assign wg_valid = q.b_v[0];
  assign wg_data = q.b_data[0];
  assign wg_len = q.b_len[0];
  assign beeper = q.beeper;
  assign led_red = q.red;
  assign led_green = q.green;
  assign led_yellow = q.yellow;
  assign relay = q.relay;
  assign pin_required = q.pin_req;
  assign keypad_locked = q.locked;
  assign prog_active = q.prog;
  assign digit_valid = q.dig_v;
  assign digit = q.dig;
  assign entry_cancel = q.cancel;
  assign entry_submit = q.submit;
  assign reason_valid = q.reason_v;
  assign reason = q.reason;
  assign intrusion_alarm_system_toggle = q.ias_tog;
  assign user_valid = q.user_v;
  assign user_found = q.user_hit;
  assign user_pin = q.user_pin;
  assign user_always = q.user_alw;
endmodule
`default_nettype wire

// ### include/rkpm_pkg.sv
`default_nettype none
package rkpm_pkg;
  localparam int unsigned CLK_HZ    = 20_000_000;
  localparam int unsigned TICK_MS   = 10;
  localparam int unsigned TICK_CYC  = CLK_HZ / 1000 * TICK_MS;

  localparam int unsigned ID_W      = 45;
  localparam int unsigned PIN_W     = 20;
  localparam int unsigned ENT_W     = ID_W + PIN_W + 1;
  localparam int unsigned PIN_LSB   = ID_W;
  localparam int unsigned ALW_POS   = ID_W + PIN_W;
  localparam int unsigned DEPTH     = 16;
  localparam int unsigned IDX_W     = 4;
  localparam int unsigned DIG_N     = 11;

  // pin stored in bcd digits
  localparam logic [19:0] DEF_PIN   = 20'h12345;

  localparam logic [5:0]  WG_LEN_26 = 6'h1A;
  localparam logic [5:0]  WG_LEN_32 = 6'h20;
  localparam logic [5:0]  WG_LEN_42 = 6'h2A;
  localparam logic [5:0]  WG_LEN_44 = 6'h2C;
  localparam logic [5:0]  WG_LEN_KEY = 6'h04;
  localparam logic [1:0]  EM_FMT_26 = 2'h0;
  localparam logic [1:0]  EM_FMT_32 = 2'h1;
  localparam logic [1:0]  EM_FMT_42 = 2'h2;

  localparam logic [1:0]  KP_CODE   = 2'h0;
  localparam logic [1:0]  KP_PIN    = 2'h1;
  localparam logic [1:0]  KP_ID     = 2'h2;
  localparam logic [3:0]  KEY_0     = 4'h0;
  localparam logic [3:0]  KEY_STAR  = 4'hA;
  localparam logic [3:0]  KEY_HASH  = 4'hB;
  localparam logic [3:0]  CODE_10   = 4'hA;
  localparam logic [3:0]  CODE_0    = 4'h0;

  localparam logic [2:0]  REPEAT_N  = 3'h5;
  localparam logic [2:0]  UNKNOWN_N = 3'h5;

  localparam int unsigned PROG_TIMEOUT_S = 15;
  localparam logic [10:0] PROG_TK   = 11'(PROG_TIMEOUT_S * 1000 / TICK_MS);
  localparam int unsigned LOCK_STEP_S = 10;
  localparam int unsigned LOCK_STEP_TK = LOCK_STEP_S * 1000 / TICK_MS;
  localparam int unsigned BEEP_MS   = 500;
  localparam logic [7:0]  BEEP_TK   = 8'(BEEP_MS / TICK_MS);
  localparam logic [7:0]  PU_END_TK = 8'(3 * BEEP_MS / TICK_MS);
  localparam int unsigned GREEN_MS  = 100;
  localparam logic [3:0]  GREEN_TK  = 4'(GREEN_MS / TICK_MS);
  localparam int unsigned FLASH_SLOW_BIT = 6;
  localparam int unsigned FLASH_FAST_BIT = 4;

  localparam logic [3:0]  FILT_RST  = 4'h7;

  typedef enum logic [4:0] {
    PM_OFF = 5'h01,
    PM_INS = 5'h02,
    PM_DEL = 5'h04,
    PM_NBR = 5'h08,
    PM_REF = 5'h10
  } rkpm_pm_t;

  typedef enum logic [2:0] {
    SP_LOOK = 3'h1,
    SP_DEL  = 3'h2,
    SP_REF  = 3'h4
  } rkpm_purp_t;
endpackage
`default_nettype wire
